// [verilog/pcw_pkg.sv]
/*
  Constants shared by the single-wire pulse-count register writer.
  Assumes a 25 MHz system clock; durations are given in nanoseconds.
*/
package pcw_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // Glitch, latch and end-of-frame windows (ns)
  localparam int GLITCH_NS     = 200;
  localparam int LATCH_NS      = 12000;
  localparam int END_NS        = 405000;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_CYC     = LATCH_NS / CLK_PERIOD_NS;
  localparam int END_CYC       = END_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 20;
  localparam int WORD_W        = 6;

  // Register addresses
  localparam logic [5:0] ADDR_FLASH   = 6'h01;
  localparam logic [5:0] ADDR_TORCH   = 6'h02;
  localparam logic [5:0] ADDR_GDUR    = 6'h03;
  localparam logic [5:0] ADDR_BATT    = 6'h04;
  localparam logic [5:0] ADDR_GCUR    = 6'h05;
  // Largest data accepted per register
  localparam logic [5:0] MAX_FLASH    = 6'h1f;
  localparam logic [5:0] MAX_TORCH    = 6'h1f;
  localparam logic [5:0] MAX_GDUR     = 6'h07;
  localparam logic [5:0] MAX_BATT     = 6'h09;
  localparam logic [5:0] MAX_GCUR     = 6'h05;
  // Reset values
  localparam logic [4:0] RST_FLASH    = 5'h04;
  localparam logic [4:0] RST_TORCH    = 5'h04;
  localparam logic [2:0] RST_GDUR     = 3'h7;
  localparam logic [3:0] RST_BATT     = 4'h1;
  localparam logic [2:0] RST_GCUR     = 3'h4;
  // Field positions
  localparam int GO_BIT               = 4;
  localparam int LEVEL_MSB            = 3;

  // Flash current in mA per level code
  localparam logic [10:0] FLASH_TOP_MA  = 11'h4b0;
  localparam logic [10:0] FLASH_STEP_MA = 11'h032;
  localparam logic [10:0] FLASH_14_MA   = 11'h190;
  localparam logic [10:0] FLASH_15_MA   = 11'h0fa;
  // Torch current in tenths of mA per level code
  localparam logic [11:0] TORCH_TOP_DMA  = 12'hbb8;
  localparam logic [11:0] TORCH_STEP_DMA = 12'h07d;
  localparam logic [11:0] TORCH_14_DMA   = 12'h3e8;
  localparam logic [11:0] TORCH_15_DMA   = 12'h271;
  localparam logic [3:0]  CODE_14        = 4'he;
  localparam logic [3:0]  CODE_15        = 4'hf;

  typedef enum logic [3:0] {
    PCW_IDLE  = 4'b0001,
    PCW_WORD  = 4'b0010,
    PCW_GAP   = 4'b0100,
    PCW_ERROR = 4'b1000
  } pcw_state_e;
endpackage

// [verilog/pcw_line_filter.sv]
/*
  Line synchroniser and glitch filter for the pulse line.
  Assumes the line is synchronous-ish and sampled on clk; output is the
  filtered level, changing only after a stable run of GLITCH_CYC cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pcw_line_filter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Line
  input  wire logic line_in,
  output logic      line_out
);
  logic                    sync_a;
  logic                    sync_b;
  logic [pcw_pkg::CNT_W-1:0] run;

  // [R20] Two-stage synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else if (clk_en) begin
      sync_a <= line_in;
      sync_b <= sync_a;
    end
  end

  // [R03] Reject short glitches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run      <= '0;
      line_out <= 1'b1;
    end else if (clk_en) begin
      if (sync_b == line_out) begin
        run <= '0;
      end else if (run >= pcw_pkg::CNT_W'(pcw_pkg::GLITCH_CYC - 1)) begin
        run      <= '0;
        line_out <= sync_b;
      end else begin
        run <= run + 1'b1;
      end
    end
  end
endmodule // pcw_line_filter
`default_nettype wire

// [verilog/pcw_writer.sv]
/*
  Single-wire pulse-count receiver and its five write-only control registers.
  Assumes the host drives the pulse line from a GPIO and keeps its own
  word spacing and stop time; the line idles high.
*/
//
// Behaviour
// [R01] Idle falling edge starts a frame
// [R02] First rising edge clears pulse counter
// [R03] Filter glitches below minimum low/high time
// [R04] Each rising edge adds one to word
// [R05] High past latch timeout stores shadow word
// [R06] Host sends address then data words
// [R07] Host holds high for end-of-frame stop
// [R08] Stop condition hands shadows to decoder
// [R09] Exactly two words, else discard frame
// [R10] Discard unknown address or invalid data
// [R11] Registers at addresses one to five
// [R12] Data above register maximum is discarded
// [R13] Flash resets to 4, bit4 enables
// [R14] Flash level code maps to current
// [R15] Torch resets to 4, bit4 enables
// [R16] Torch off when torch go bit zero
// [R17] Torch level code maps to current
// [R18] Long low enters shutdown, defaults restored
// [R19] Mid-length low aborts current frame
// [R20] Synchronise line, parameterised duration counters
`timescale 1ns/1ps
`default_nettype none
module pcw_writer #(
  parameter int END_CYCLES = pcw_pkg::END_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Single-wire link
  input  wire logic        pulse_line,
  // Register contents
  output logic [4:0]       flash_enable_current,
  output logic [4:0]       torch_enable_current,
  output logic [2:0]       safety_timer_duration,
  output logic [3:0]       low_battery_threshold,
  output logic [2:0]       safety_timer_current_threshold,
  // Decoded controls
  output logic             flash_go_bit,
  output logic             torch_on,
  output logic [10:0]      flash_current_ma,
  output logic [11:0]      torch_current_dma,
  output logic             shutdown,
  output logic             frame_done
);
  localparam logic [pcw_pkg::CNT_W-1:0] LAT_LIM = pcw_pkg::CNT_W'(pcw_pkg::LATCH_CYC);
  localparam logic [pcw_pkg::CNT_W-1:0] END_LIM = pcw_pkg::CNT_W'(END_CYCLES);

  logic                         line_f;
  logic                         line_d;
  logic                         fall;
  logic                         rise;
  pcw_pkg::pcw_state_e          state;
  logic [pcw_pkg::CNT_W-1:0]    hi_cnt;
  logic [pcw_pkg::CNT_W-1:0]    lo_cnt;
  logic [pcw_pkg::WORD_W-1:0]   count;
  logic [pcw_pkg::WORD_W-1:0]   shadow_addr;
  logic [pcw_pkg::WORD_W-1:0]   shadow_data;
  logic [1:0]                   words;
  logic                         first_rise;
  logic                         latch_evt;
  logic                         stop_evt;
  logic                         abort_evt;
  logic                         shut_evt;
  logic                         commit;

  function automatic logic [5:0] max_for(input logic [5:0] addr);
    case (addr)
      pcw_pkg::ADDR_FLASH: max_for = pcw_pkg::MAX_FLASH;
      pcw_pkg::ADDR_TORCH: max_for = pcw_pkg::MAX_TORCH;
      pcw_pkg::ADDR_GDUR:  max_for = pcw_pkg::MAX_GDUR;
      pcw_pkg::ADDR_BATT:  max_for = pcw_pkg::MAX_BATT;
      pcw_pkg::ADDR_GCUR:  max_for = pcw_pkg::MAX_GCUR;
      default:             max_for = 6'h00;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [5:0] addr);
    addr_ok = (addr >= pcw_pkg::ADDR_FLASH) && (addr <= pcw_pkg::ADDR_GCUR);
  endfunction

  pcw_line_filter u_filter (
    .clk      (clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .line_in  (pulse_line),
    .line_out (line_f)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_d <= 1'b1;
    end else if (clk_en) begin
      line_d <= line_f;
    end
  end

  assign fall = line_d & ~line_f;
  assign rise = ~line_d & line_f;

  // [R20] Duration counters for high and low runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else if (clk_en) begin
      if (!line_f || rise) begin
        hi_cnt <= '0;
      end else if (hi_cnt != END_LIM) begin
        hi_cnt <= hi_cnt + 1'b1;
      end
      if (line_f || fall) begin
        lo_cnt <= '0;
      end else if (lo_cnt != END_LIM) begin
        lo_cnt <= lo_cnt + 1'b1;
      end
    end
  end

  // Events fire once as a counter crosses its limit
  assign latch_evt = line_f && (hi_cnt == LAT_LIM - 1'b1) && (state == pcw_pkg::PCW_WORD);
  assign stop_evt  = line_f && (hi_cnt == END_LIM - 1'b1) && (state == pcw_pkg::PCW_GAP);
  assign abort_evt = !line_f && (lo_cnt == LAT_LIM - 1'b1) && (state != pcw_pkg::PCW_IDLE);
  assign shut_evt  = !line_f && (lo_cnt == END_LIM - 1'b1);

  // [R09] Two words exactly, checked at stop
  // [R10] Known address and valid data only
  // [R12] Reject data above the register maximum
  assign commit = stop_evt && (words == 2'd2) && addr_ok(shadow_addr) &&
                  (shadow_data <= max_for(shadow_addr));

  // [R01] Frame start on idle falling edge
  // [R19] Long low aborts the frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= pcw_pkg::PCW_IDLE;
    end else if (clk_en) begin
      case (state)
        pcw_pkg::PCW_IDLE: begin
          if (fall) begin
            state <= pcw_pkg::PCW_WORD;
          end
        end
        pcw_pkg::PCW_WORD: begin
          if (abort_evt) begin
            state <= pcw_pkg::PCW_ERROR;
          end else if (latch_evt) begin
            state <= pcw_pkg::PCW_GAP;
          end
        end
        pcw_pkg::PCW_GAP: begin
          if (abort_evt) begin
            state <= pcw_pkg::PCW_ERROR;
          end else if (stop_evt) begin
            state <= pcw_pkg::PCW_IDLE;
          end else if (fall) begin
            state <= pcw_pkg::PCW_WORD;
          end
        end
        pcw_pkg::PCW_ERROR: begin
          // Wait for the line to return high before idling
          if (line_f) begin
            state <= pcw_pkg::PCW_IDLE;
          end
        end
        default: state <= pcw_pkg::PCW_IDLE;
      endcase
    end
  end

  // [R02] First rising edge clears counter
  // [R04] Rising edge counts a pulse
  // [R05] Latch word into shadow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count       <= '0;
      first_rise  <= 1'b0;
      words       <= '0;
      shadow_addr <= '0;
      shadow_data <= '0;
    end else if (clk_en) begin
      if (state == pcw_pkg::PCW_IDLE && fall) begin
        first_rise <= 1'b1;
        words      <= '0;
      end
      if (state == pcw_pkg::PCW_GAP && fall) begin
        count <= '0;
      end else if (rise && state == pcw_pkg::PCW_WORD) begin
        first_rise <= 1'b0;
        // Saturate so an over-long word still fails the max check
        if (first_rise) begin
          count <= 6'h01;
        end else if (count != 6'h3f) begin
          count <= count + 1'b1;
        end
      end
      if (latch_evt) begin
        if (words == 2'd0) begin
          shadow_addr <= count;
        end else if (words == 2'd1) begin
          shadow_data <= count;
        end
        if (words != 2'd3) begin
          words <= words + 1'b1;
        end
      end
    end
  end

  // [R08] Stop condition starts register update
  // [R11] Write the addressed register
  // [R18] Shutdown restores defaults
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_enable_current           <= pcw_pkg::RST_FLASH;
      torch_enable_current           <= pcw_pkg::RST_TORCH;
      safety_timer_duration          <= pcw_pkg::RST_GDUR;
      low_battery_threshold          <= pcw_pkg::RST_BATT;
      safety_timer_current_threshold <= pcw_pkg::RST_GCUR;
    end else if (clk_en) begin
      if (shut_evt) begin
        flash_enable_current           <= pcw_pkg::RST_FLASH;
        torch_enable_current           <= pcw_pkg::RST_TORCH;
        safety_timer_duration          <= pcw_pkg::RST_GDUR;
        low_battery_threshold          <= pcw_pkg::RST_BATT;
        safety_timer_current_threshold <= pcw_pkg::RST_GCUR;
      end else if (commit) begin
        case (shadow_addr)
          pcw_pkg::ADDR_FLASH: flash_enable_current <= shadow_data[4:0];
          pcw_pkg::ADDR_TORCH: torch_enable_current <= shadow_data[4:0];
          pcw_pkg::ADDR_GDUR:  safety_timer_duration <= shadow_data[2:0];
          pcw_pkg::ADDR_BATT:  low_battery_threshold <= shadow_data[3:0];
          pcw_pkg::ADDR_GCUR:  safety_timer_current_threshold <= shadow_data[2:0];
          default: ;
        endcase
      end
    end
  end

  // Shutdown flag holds until the line returns high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shutdown   <= 1'b0;
      frame_done <= 1'b0;
    end else if (clk_en) begin
      frame_done <= commit;
      if (shut_evt) begin
        shutdown <= 1'b1;
      end else if (line_f) begin
        shutdown <= 1'b0;
      end
    end
  end

  // [R13] Flash go bit is bit 4
  assign flash_go_bit = flash_enable_current[pcw_pkg::GO_BIT];
  // [R15] Torch go bit is bit 4
  // [R16] Torch dark while go bit zero
  assign torch_on = torch_enable_current[pcw_pkg::GO_BIT];

  // [R14] Flash level code to current
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_current_ma <= '0;
    end else if (clk_en) begin
      case (flash_enable_current[pcw_pkg::LEVEL_MSB:0])
        pcw_pkg::CODE_14: flash_current_ma <= pcw_pkg::FLASH_14_MA;
        pcw_pkg::CODE_15: flash_current_ma <= pcw_pkg::FLASH_15_MA;
        default: flash_current_ma <= pcw_pkg::FLASH_TOP_MA - 11'(pcw_pkg::FLASH_STEP_MA *
                   flash_enable_current[pcw_pkg::LEVEL_MSB:0]);
      endcase
    end
  end

  // [R17] Torch level code to current
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      torch_current_dma <= '0;
    end else if (clk_en) begin
      case (torch_enable_current[pcw_pkg::LEVEL_MSB:0])
        pcw_pkg::CODE_14: torch_current_dma <= pcw_pkg::TORCH_14_DMA;
        pcw_pkg::CODE_15: torch_current_dma <= pcw_pkg::TORCH_15_DMA;
        default: torch_current_dma <= pcw_pkg::TORCH_TOP_DMA - 12'(pcw_pkg::TORCH_STEP_DMA *
                   torch_enable_current[pcw_pkg::LEVEL_MSB:0]);
      endcase
    end
  end

  // [R12] Over-range data leaves flash and torch registers alone
  chk_no_bad_write: assert property (@(posedge clk) disable iff (reset)
    (stop_evt && clk_en && (shadow_data > max_for(shadow_addr)) && !shut_evt)
      |=> $stable(flash_enable_current) && $stable(torch_enable_current))
    else $error("over-range data changed a register");

  // [R09] Commit only with two words
  chk_two_words: assert property (@(posedge clk) disable iff (reset)
    commit |-> (words == 2'd2))
    else $error("commit without exactly two words");

  // [R11] Flash write lands next cycle
  chk_flash_write: assert property (@(posedge clk) disable iff (reset)
    (commit && clk_en && shadow_addr == pcw_pkg::ADDR_FLASH && !shut_evt)
      |=> flash_enable_current == $past(shadow_data[4:0]))
    else $error("flash register not written");

  // [R18] Shutdown restores defaults
  chk_shutdown_dflt: assert property (@(posedge clk) disable iff (reset)
    (shut_evt && clk_en) |=> (flash_enable_current == pcw_pkg::RST_FLASH) &&
      (torch_enable_current == pcw_pkg::RST_TORCH) && shutdown)
    else $error("shutdown did not restore defaults");

  // [R19] Long low aborts the frame
  chk_abort_frame: assert property (@(posedge clk) disable iff (reset)
    (abort_evt && clk_en) |=> (state == pcw_pkg::PCW_ERROR))
    else $error("long low did not abort frame");

  // [R16] Torch follows its go bit
  chk_torch_off: assert property (@(posedge clk) disable iff (reset)
    !torch_enable_current[pcw_pkg::GO_BIT] |-> !torch_on)
    else $error("torch lit with go bit clear");

  // [R05] Latch stores count into shadow
  chk_latch_addr: assert property (@(posedge clk) disable iff (reset)
    (latch_evt && clk_en && words == 2'd0) |=> (shadow_addr == $past(count)) && (words == 2'd1))
    else $error("address word not latched");

  // [R10] Bad address leaves registers alone
  chk_bad_addr: assert property (@(posedge clk) disable iff (reset)
    (stop_evt && !addr_ok(shadow_addr)) |-> !commit)
    else $error("write to unknown address");
endmodule // pcw_writer
`default_nettype wire

// [verif/pcw_host_model.sv]
/*
  Host GPIO model that drives the pulse line push-pull.
  Assumes one bench process calls its tasks, on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pcw_host_model #(
  parameter int STOP_CYC = 800
) (
  // Clock
  input  wire logic clk,
  // Line
  output var logic  pulse_line
);
  initial pulse_line = 1'b1;

  // Change just after an edge, then hold for whole cycles
  task automatic level(input logic v, input int cyc);
    @(posedge clk);
    pulse_line <= v;
    repeat (cyc - 1) @(posedge clk);
  endtask

  // low and high runs kept well above the glitch window
  task automatic word(input int n);
    for (int i = 0; i < n; i++) begin
      level(1'b0, 10);
      level(1'b1, 10);
    end
  endtask

  // address, latch gap, data, then stop
  task automatic frame(input int a, input int d);
    word(a);
    level(1'b1, pcw_pkg::LATCH_CYC + 20);
    word(d);
    level(1'b1, STOP_CYC);
  endtask
endmodule // pcw_host_model
`default_nettype wire

// [verif/pcw_writer_bench.sv]
/*
  Self-checking bench for the pulse-count register writer.
  Assumes the host model on the line; clk_en held high throughout.
*/
`timescale 1ns/1ps
`default_nettype none
module pcw_writer_bench;
  // Short stop window keeps the run brief
  localparam int END_SIM = 600;
  localparam int GAP = pcw_pkg::LATCH_CYC + 20;
  typedef struct packed {
    logic [5:0] a;
    logic [5:0] d;
  } pcw_row_s;

  logic        clk, reset, clk_en;
  logic        pulse_line;
  logic [4:0]  fl, to;
  logic [2:0]  gd, gc;
  logic [3:0]  bt;
  logic        fgo, ton, sd, fdone;
  logic [10:0] fma;
  logic [11:0] tdma;
  int          fail_count, n_compared, done_seen, done_exp;
  logic [4:0]  e_fl, e_to;
  logic [2:0]  e_gd, e_gc;
  logic [3:0]  e_bt;
  pcw_row_s    rows [13] = '{'{6'h01, 6'h11}, '{6'h02, 6'h1e}, '{6'h03, 6'h01},
    '{6'h04, 6'h09}, '{6'h05, 6'h05}, '{6'h01, 6'h0f}, '{6'h02, 6'h0e},
    '{6'h01, 6'h20}, '{6'h03, 6'h08}, '{6'h04, 6'h0a}, '{6'h05, 6'h06},
    '{6'h06, 6'h01}, '{6'h02, 6'h13}};

  pcw_writer #(.END_CYCLES(END_SIM)) i_dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .pulse_line(pulse_line),
    .flash_enable_current(fl), .torch_enable_current(to),
    .safety_timer_duration(gd), .low_battery_threshold(bt),
    .safety_timer_current_threshold(gc), .flash_go_bit(fgo), .torch_on(ton),
    .flash_current_ma(fma), .torch_current_dma(tdma), .shutdown(sd),
    .frame_done(fdone)
  );
  pcw_host_model #(.STOP_CYC(END_SIM + 200)) i_host (.clk(clk), .pulse_line(pulse_line));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (fdone === 1'b1) done_seen <= done_seen + 1;
  end

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [10:0] flash_ma(input logic [3:0] c);
    if (c == 4'he) return pcw_pkg::FLASH_14_MA;
    if (c == 4'hf) return pcw_pkg::FLASH_15_MA;
    return pcw_pkg::FLASH_TOP_MA - 11'(c) * pcw_pkg::FLASH_STEP_MA;
  endfunction

  function automatic logic [11:0] torch_dma(input logic [3:0] c);
    if (c == 4'he) return pcw_pkg::TORCH_14_DMA;
    if (c == 4'hf) return pcw_pkg::TORCH_15_DMA;
    return pcw_pkg::TORCH_TOP_DMA - 12'(c) * pcw_pkg::TORCH_STEP_DMA;
  endfunction

  task automatic defaults();
    e_fl = pcw_pkg::RST_FLASH;
    e_to = pcw_pkg::RST_TORCH;
    e_gd = pcw_pkg::RST_GDUR;
    e_bt = pcw_pkg::RST_BATT;
    e_gc = pcw_pkg::RST_GCUR;
  endtask

  // Expected effect of one frame, worked from address and limits
  task automatic apply(input logic [5:0] a, input logic [5:0] d);
    logic ok;
    ok = 1'b0;
    case (a)
      6'h01: if (d <= 6'h1f) begin e_fl = d[4:0]; ok = 1'b1; end
      6'h02: if (d <= 6'h1f) begin e_to = d[4:0]; ok = 1'b1; end
      6'h03: if (d <= 6'h07) begin e_gd = d[2:0]; ok = 1'b1; end
      6'h04: if (d <= 6'h09) begin e_bt = d[3:0]; ok = 1'b1; end
      6'h05: if (d <= 6'h05) begin e_gc = d[2:0]; ok = 1'b1; end
      default: ok = 1'b0;
    endcase
    if (ok) done_exp++;
  endtask

  task automatic check_all(input string test);
    #1;
    check("flash reg", 12'(fl), 12'(e_fl));
    check("torch reg", 12'(to), 12'(e_to));
    check("duration reg", 12'(gd), 12'(e_gd));
    check("battery reg", 12'(bt), 12'(e_bt));
    check("guard current reg", 12'(gc), 12'(e_gc));
    check("flash go", 12'(fgo), 12'(e_fl[4]));
    check("torch on", 12'(ton), 12'(e_to[4]));
    check("flash ma", 12'(fma), 12'(flash_ma(e_fl[3:0])));
    check("torch dma", tdma, torch_dma(e_to[3:0]));
    check("done count", 12'(done_seen), 12'(done_exp));
    $display("test %s finished", test);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    defaults();
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check_all("reset values");
    foreach (rows[i]) begin
      i_host.frame(rows[i].a, rows[i].d);
      apply(rows[i].a, rows[i].d);
      check_all($sformatf("row %0d", i));
    end
    // Lone word then stop
    i_host.word(3);
    i_host.level(1'b1, END_SIM + 200);
    check_all("lone word");
    // Three words in one frame
    i_host.word(4);
    i_host.level(1'b1, GAP);
    i_host.word(2);
    i_host.level(1'b1, GAP);
    i_host.word(1);
    i_host.level(1'b1, END_SIM + 200);
    check_all("three words");
    // Short low inside the data word must not count
    i_host.word(4);
    i_host.level(1'b1, GAP);
    i_host.word(2);
    i_host.level(1'b0, 2);
    i_host.level(1'b1, 10);
    i_host.word(1);
    i_host.level(1'b1, END_SIM + 200);
    apply(6'h04, 6'h03);
    check_all("glitch");
    // Mid-length low after the address aborts
    i_host.word(2);
    i_host.level(1'b1, GAP);
    i_host.word(5);
    i_host.level(1'b0, pcw_pkg::LATCH_CYC + 100);
    i_host.level(1'b1, END_SIM + 200);
    check_all("abort");
    // Long low shuts down and restores defaults
    i_host.level(1'b0, END_SIM + 100);
    #1;
    check("shutdown set", 12'(sd), 12'h001);
    defaults();
    check_all("shutdown");
    i_host.level(1'b1, 50);
    #1;
    check("shutdown clear", 12'(sd), 12'h000);
    // Second reset after a write
    i_host.frame(1, 20);
    apply(6'h01, 6'h14);
    check_all("write before reset");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    defaults();
    check_all("second reset");
    wrap_up();
  end
endmodule // pcw_writer_bench
`default_nettype wire
